// [verilog/lcddc_pkg.sv]
// Package of register map, field positions and timing counts for the LCD drive control block
package lcddc_pkg;
  // Offsets are word indices; the bus byte address is four times the index
  localparam logic [15:0] LCDDC_BOOST_OFF    = 16'h2020;
  localparam logic [15:0] LCDDC_DISPLAY_OFF  = 16'h2021;
  localparam logic [15:0] LCDDC_STATUS_OFF   = 16'h2024;
  localparam int          LCDDC_BOOST_BIT    = 7;
  localparam int          LCDDC_ENABLE_BIT   = 5;
  localparam int          LCDDC_RATE_LSB     = 0;
  localparam int          LCDDC_RATE_W       = 2;
  localparam logic [7:0]  LCDDC_BOOST_RESET  = 8'h00;
  localparam logic [7:0]  LCDDC_DISPLAY_RESET = 8'h00;
  localparam int          LCDDC_BASE_DIV_LOG2 = 7;
  localparam int          LCDDC_RATE_SLOW_LOG2 = 9;
  localparam int          LCDDC_DIV_W        = LCDDC_BASE_DIV_LOG2 + LCDDC_RATE_SLOW_LOG2;
  localparam int          LCDDC_COM_N        = 4;
  localparam int          LCDDC_SEG_N        = 8;
  localparam logic [1:0]  LCDDC_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  LCDDC_RESP_SLVERR  = 2'b10;
  typedef enum logic [1:0] {
    LCDDC_W_IDLE = 2'b00,
    LCDDC_W_RESP = 2'b01
  } lcddc_wstate_t;
endpackage : lcddc_pkg

// [verilog/lcddc_sync.sv]
// Three-flop synchroniser that reports a change once the last two stages agree
`timescale 1ns/10ps
`default_nettype none
module lcddc_sync
  import lcddc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Pin and filtered level
  input  wire logic async_i,
  output logic      level_o
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       level;
  logic       next_level;

  always_comb begin
    next_stage = {stage[1:0], async_i};
    next_level = (stage[2] == stage[1]) ? stage[2] : level;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;
endmodule : lcddc_sync
`default_nettype wire

// [verilog/lcddc_rate.sv]
// Rate divider: base clock over 128, then one of four glass update rates
`timescale 1ns/10ps
`default_nettype none
module lcddc_rate
  import lcddc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Control
  input  wire logic                    run_i,
  input  wire logic [LCDDC_RATE_W-1:0] glass_rate_select_i,
  // Update tick
  output logic                         tick_o
);
  logic [LCDDC_DIV_W-1:0] count;
  logic [LCDDC_DIV_W-1:0] next_count;
  logic [LCDDC_DIV_W-1:0] mask;

  // 00 -> 2^16 cycles, 11 -> 2^13 cycles of the converter clock
  always_comb begin
    mask       = LCDDC_DIV_W'({LCDDC_DIV_W{1'b1}} >> glass_rate_select_i);
    next_count = run_i ? count + 1'b1 : '0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tick_o = run_i && ((count & mask) == mask);
endmodule : lcddc_rate
`default_nettype wire

// [verilog/lcddc_top.sv]
// LCD drive control: AXI4-Lite registers, rate divider, glass drive and watchdog strap
`timescale 1ns/10ps
`default_nettype none
module lcddc_top
  import lcddc_pkg::*;
(
  // Clock and reset (converter clock domain)
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // AXI4-Lite write address and data
  input  wire logic [15:0]            s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [15:0]            s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  // Glass drive
  output logic [LCDDC_COM_N-1:0]      common_drive_o,
  output logic [LCDDC_SEG_N-1:0]      segment_drive_o,
  input  wire logic [LCDDC_SEG_N-1:0] segment_pattern_i,
  output logic                        bias_level_top_o,
  output logic                        bias_level_mid_o,
  output logic                        bias_level_low_o,
  output logic                        boost_enable_o,
  // Watchdog strap
  input  wire logic                   watchdog_disable_sense_i,
  output logic                        watchdog_enable_o
);
  // Register state
  logic [7:0]              boost_reg;
  logic [7:0]              display_reg;
  logic [7:0]              next_boost_reg;
  logic [7:0]              next_display_reg;
  // Write channel state
  lcddc_wstate_t           wstate;
  lcddc_wstate_t           next_wstate;
  logic                    aw_held;
  logic                    next_aw_held;
  logic                    w_held;
  logic                    next_w_held;
  logic [15:0]             aw_addr;
  logic [15:0]             next_aw_addr;
  logic [31:0]             w_data;
  logic [31:0]             next_w_data;
  logic                    w_lane0;
  logic                    next_w_lane0;
  logic [1:0]              bresp;
  logic [1:0]              next_bresp;
  // Read channel state
  logic                    rvalid;
  logic                    next_rvalid;
  logic [31:0]             rdata;
  logic [31:0]             next_rdata;
  logic [1:0]              rresp;
  logic [1:0]              next_rresp;
  // Glass state
  logic [LCDDC_COM_N-1:0]  com_phase;
  logic [LCDDC_COM_N-1:0]  next_com_phase;
  logic [LCDDC_SEG_N-1:0]  seg_q;
  logic [LCDDC_SEG_N-1:0]  next_seg_q;
  logic                    wd_enable;
  logic                    next_wd_enable;
  // Derived
  logic                    display_on;
  logic [LCDDC_RATE_W-1:0] rate_sel;
  logic                    tick;
  logic                    sense_level;
  logic                    do_write;

  assign display_on = display_reg[LCDDC_ENABLE_BIT];
  assign rate_sel   = display_reg[LCDDC_RATE_LSB +: LCDDC_RATE_W];

  lcddc_rate lcddc_rate_inst (
    .clk_i               (clk_i),
    .sys_rst_i           (sys_rst_i),
    .run_i               (display_on),
    .glass_rate_select_i (rate_sel),
    .tick_o              (tick)
  );

  lcddc_sync lcddc_sync_inst (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (watchdog_disable_sense_i),
    .level_o   (sense_level)
  );

  // Write path: address and data are taken in either order, then one response
  assign do_write = (wstate == LCDDC_W_IDLE) && aw_held && w_held;

  always_comb begin
    next_wstate      = wstate;
    next_aw_held     = aw_held;
    next_w_held      = w_held;
    next_aw_addr     = aw_addr;
    next_w_data      = w_data;
    next_w_lane0     = w_lane0;
    next_bresp       = bresp;
    next_boost_reg   = boost_reg;
    next_display_reg = display_reg;
    case (wstate)
      LCDDC_W_IDLE: begin
        if (s_axi_awvalid_i && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_held) begin
          next_w_held  = 1'b1;
          next_w_data  = s_axi_wdata_i;
          next_w_lane0 = s_axi_wstrb_i[0];
        end
        if (do_write) begin
          next_bresp = LCDDC_RESP_OKAY;
          // Whole byte replaced; software must read-modify-write one field
          // Word index decode keeps the two neighbouring registers apart
          if (aw_addr[15:2] == LCDDC_BOOST_OFF[13:0]) begin
            if (w_lane0) next_boost_reg = w_data[7:0];
          end else if (aw_addr[15:2] == LCDDC_DISPLAY_OFF[13:0]) begin
            if (w_lane0) next_display_reg = w_data[7:0];
          end else begin
            next_bresp = LCDDC_RESP_SLVERR;
          end
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_wstate  = LCDDC_W_RESP;
        end
      end
      LCDDC_W_RESP: begin
        if (s_axi_bready_i) next_wstate = LCDDC_W_IDLE;
      end
      default: next_wstate = LCDDC_W_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wstate      <= LCDDC_W_IDLE;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr     <= 16'h0000;
      w_data      <= 32'h0000_0000;
      w_lane0     <= 1'b0;
      bresp       <= LCDDC_RESP_OKAY;
      boost_reg   <= LCDDC_BOOST_RESET;
      display_reg <= LCDDC_DISPLAY_RESET;
    end else begin
      wstate      <= next_wstate;
      aw_held     <= next_aw_held;
      w_held      <= next_w_held;
      aw_addr     <= next_aw_addr;
      w_data      <= next_w_data;
      w_lane0     <= next_w_lane0;
      bresp       <= next_bresp;
      boost_reg   <= next_boost_reg;
      display_reg <= next_display_reg;
    end
  end

  assign s_axi_awready_o = (wstate == LCDDC_W_IDLE) && !aw_held;
  assign s_axi_wready_o  = (wstate == LCDDC_W_IDLE) && !w_held;
  assign s_axi_bvalid_o  = (wstate == LCDDC_W_RESP);
  assign s_axi_bresp_o   = bresp;

  // Read path: one cycle from address to data
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid) begin
      if (s_axi_rready_i) next_rvalid = 1'b0;
    end else if (s_axi_arvalid_i) begin
      next_rvalid = 1'b1;
      next_rresp  = LCDDC_RESP_OKAY;
      if (s_axi_araddr_i[15:2] == LCDDC_BOOST_OFF[13:0]) begin
        next_rdata = {24'h000000, boost_reg};
      end else if (s_axi_araddr_i[15:2] == LCDDC_DISPLAY_OFF[13:0]) begin
        next_rdata = {24'h000000, display_reg};
      end else if (s_axi_araddr_i[15:2] == LCDDC_STATUS_OFF[13:0]) begin
        next_rdata = {30'h0000_0000, sense_level, wd_enable};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = LCDDC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= LCDDC_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // Glass drive: a walking common and latched segments, stepping only on the tick
  always_comb begin
    next_com_phase = com_phase;
    next_seg_q     = seg_q;
    next_wd_enable = !sense_level;
    if (!display_on) begin
      next_com_phase = '0;
      next_seg_q     = '0;
    end else if (tick) begin
      next_com_phase = (com_phase == '0) ? LCDDC_COM_N'(1)
                     : {com_phase[LCDDC_COM_N-2:0], com_phase[LCDDC_COM_N-1]};
      next_seg_q     = segment_pattern_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      com_phase <= '0;
      seg_q     <= '0;
      wd_enable <= 1'b1;
    end else begin
      com_phase <= next_com_phase;
      seg_q     <= next_seg_q;
      wd_enable <= next_wd_enable;
    end
  end

  // Gating on the live bit as well makes the outputs drop in the cycle after the write
  assign common_drive_o    = display_on ? com_phase : '0;
  assign segment_drive_o   = display_on ? seg_q : '0;
  assign bias_level_top_o  = display_on;
  assign bias_level_mid_o  = display_on;
  assign bias_level_low_o  = display_on;
  assign boost_enable_o    = boost_reg[LCDDC_BOOST_BIT];
  assign watchdog_enable_o = wd_enable;

  // Checks
  property p_off_ground;
    @(posedge clk_i) disable iff (sys_rst_i)
      !display_on |-> (common_drive_o == '0) && (segment_drive_o == '0) && !bias_level_top_o;
  endproperty
  a_off_ground: assert property (p_off_ground) else $error("drive while disabled");

  property p_com_steady;
    @(posedge clk_i) disable iff (sys_rst_i)
      display_on && $past(display_on) && !$past(tick) |-> $stable(com_phase);
  endproperty
  a_com_steady: assert property (p_com_steady) else $error("common moved off tick");

  property p_boost_follow;
    @(posedge clk_i) disable iff (sys_rst_i)
      do_write && (aw_addr[15:2] == LCDDC_BOOST_OFF[13:0]) && w_lane0
      |=> boost_enable_o == $past(w_data[7]);
  endproperty
  a_boost_follow: assert property (p_boost_follow) else $error("boost not written");

  property p_disp_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      do_write && (aw_addr[15:2] == LCDDC_DISPLAY_OFF[13:0]) && w_lane0
      |=> display_reg == $past(w_data[7:0]);
  endproperty
  a_disp_write: assert property (p_disp_write) else $error("byte not written");

  property p_readback;
    @(posedge clk_i) disable iff (sys_rst_i)
      !rvalid && s_axi_arvalid_i && (s_axi_araddr_i[15:2] == LCDDC_DISPLAY_OFF[13:0])
      |=> rvalid && (rdata[7:0] == $past(display_reg));
  endproperty
  a_readback: assert property (p_readback) else $error("bad readback");

  property p_wd_high;
    @(posedge clk_i) disable iff (sys_rst_i)
      sense_level |=> !watchdog_enable_o;
  endproperty
  a_wd_high: assert property (p_wd_high) else $error("watchdog on at strap");

  property p_wd_low;
    @(posedge clk_i) disable iff (sys_rst_i)
      !sense_level |=> watchdog_enable_o;
  endproperty
  a_wd_low: assert property (p_wd_low) else $error("watchdog off low");

  property p_tick_rate;
    @(posedge clk_i) disable iff (sys_rst_i)
      tick && (rate_sel == 2'b11) && display_on |=> !tick [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("ticks too close");

  property p_com_on;
    @(posedge clk_i) disable iff (sys_rst_i)
      display_on && tick |=> display_on |-> (common_drive_o != '0);
  endproperty
  a_com_on: assert property (p_com_on) else $error("no common drive");
endmodule : lcddc_top
`default_nettype wire

// [testbench/lcddc_glass.sv]
// Passive multiplexed glass model: counts common steps and flags drive on unbiased rails
`timescale 1ns/10ps
`default_nettype none
module lcddc_glass
  import lcddc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // Glass lines
  input  wire logic [LCDDC_COM_N-1:0] common_i,
  input  wire logic [LCDDC_SEG_N-1:0] segment_i,
  input  wire logic                   bias_level_top_i,
  input  wire logic                   bias_level_mid_i,
  input  wire logic                   bias_level_low_i,
  // Observations
  output logic [31:0]                 com_edges_o,
  output logic                        unbiased_drive_o
);
  logic [LCDDC_COM_N-1:0] com_q;
  logic                   rails_low;

  assign rails_low = !(bias_level_top_i || bias_level_mid_i || bias_level_low_i);

  // Glass has no drive of its own; it only watches what reaches its plates
  always_ff @(posedge clk_i) begin
    com_q <= common_i;
    if (sys_rst_i) begin
      com_edges_o      <= 32'h0;
      unbiased_drive_o <= 1'b0;
    end else begin
      if (com_q !== common_i) begin
        com_edges_o <= com_edges_o + 32'h1;
      end
      if (rails_low && ((|common_i) || (|segment_i))) begin
        unbiased_drive_o <= 1'b1;
      end
    end
  end
endmodule : lcddc_glass
`default_nettype wire

// [testbench/lcd_drive_control_tb.sv]
// Self-checking bench for the LCD drive control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp, msg) begin checks_done++; if ((act) !== (exp)) begin fails++; $display("mismatch t=%0t %s", $time, msg); end end
module lcd_drive_control_tb
  import lcddc_pkg::*;
;
  // Printed display offset is not a word multiple, so each offset is a word index
  localparam int          BOOST_IDX = 'h2020;
  localparam int          DISP_IDX  = 'h2021;
  localparam logic [15:0] BOOST_A   = 16'(4 * BOOST_IDX);
  localparam logic [15:0] DISP_A    = 16'(4 * DISP_IDX);
  localparam logic [15:0] STAT_A    = 16'(4 * 'h2024);
  logic clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready, sense;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, wr_strb;
  logic [LCDDC_SEG_N-1:0] pattern;
  logic awready, wready, bvalid, arready, rvalid, b_top, b_mid, b_low, boost, wdog, unb;
  logic [1:0] bresp, rresp, resp, rd_resp;
  logic [31:0] rd, com_edges, edges0;
  logic [LCDDC_COM_N-1:0] common;
  logic [LCDDC_SEG_N-1:0] segment;
  int fails, checks_done, cyc;

  lcddc_top lcddc_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .common_drive_o(common),
    .segment_drive_o(segment), .segment_pattern_i(pattern), .bias_level_top_o(b_top),
    .bias_level_mid_o(b_mid), .bias_level_low_o(b_low), .boost_enable_o(boost),
    .watchdog_disable_sense_i(sense), .watchdog_enable_o(wdog));

  lcddc_glass lcddc_glass_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .common_i(common),
    .segment_i(segment), .bias_level_top_i(b_top), .bias_level_mid_i(b_mid),
    .bias_level_low_i(b_low), .com_edges_o(com_edges), .unbiased_drive_o(unb));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic limit_hit;
    fails++;
    $display("mismatch t=%0t wait limit reached", $time);
    end_sim();
  endtask : limit_hit

  // Called just after a rising edge; returns just after one
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge clk_i);
      n++;
      if (n > 50) limit_hit();
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw_ok && w_ok && bvalid === 1'b1) begin
        b_ok = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    @(posedge clk_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) limit_hit();
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask : axi_rd

  // Cycles until the common lines next change
  task automatic wait_com(output int c);
    logic [LCDDC_COM_N-1:0] prev;
    prev = common;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
      if (c > 70000) limit_hit();
    end while (common === prev);
  endtask : wait_com

  task automatic wait_wdog(input logic v);
    int n;
    n = 0;
    while (wdog !== v) begin
      @(posedge clk_i);
      n++;
      if (n > 10) limit_hit();
    end
  endtask : wait_wdog

  initial begin
    fails = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, sense} = 6'h00;
    {awaddr, araddr, wdata, wstrb, pattern} = '0;
    wr_strb = 4'hF;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({common, segment, b_top, b_mid, b_low}, 15'h0000, "glass not grounded")
    `CHK(wdog, 1'b1, "watchdog off after reset")
    axi_wr(BOOST_A, 8'h8E, resp);
    `CHK(resp, LCDDC_RESP_OKAY, "boost write resp")
    `CHK(boost, 1'b1, "boost not on")
    axi_rd(BOOST_A, rd);
    `CHK(rd, 32'h0000008E, "boost readback")
    axi_wr(BOOST_A, 8'h0E, resp);
    `CHK(boost, 1'b0, "boost not off")
    // Display on at the fastest rate to keep the run short
    pattern <= 8'hA5;
    axi_wr(DISP_A, 8'h27, resp);
    axi_rd(DISP_A, rd);
    `CHK(rd, 32'h00000027, "display readback")
    axi_rd(BOOST_A, rd);
    `CHK(rd, 32'h0000000E, "boost disturbed")
    `CHK({b_top, b_mid, b_low}, 3'b111, "bias rails off")
    wait_com(cyc);
    `CHK(segment, 8'hA5, "segments not sampled")
    pattern <= 8'h3C;
    repeat (100) @(posedge clk_i);
    `CHK(segment, 8'hA5, "segments moved off tick")
    wait_com(cyc);
    `CHK(cyc + 100, 8192, "rate 11 period")
    `CHK(segment, 8'h3C, "segments not resampled")
    axi_wr(DISP_A, 8'h26, resp);
    wait_com(cyc);
    wait_com(cyc);
    `CHK(cyc, 16384, "rate 10 period")
    // Whole-byte write turns display off and drops the rate field
    axi_wr(DISP_A, 8'h04, resp);
    axi_rd(DISP_A, rd);
    `CHK(rd, 32'h00000004, "whole byte write")
    `CHK({common, segment, b_top, b_mid, b_low}, 15'h0000, "glass driven off")
    edges0 = com_edges;
    repeat (9000) @(posedge clk_i);
    `CHK(com_edges, edges0, "commons stepped while off")
    axi_wr(16'h0100, 8'hFF, resp);
    `CHK(resp, LCDDC_RESP_SLVERR, "unmapped write accepted")
    axi_rd(BOOST_A, rd);
    `CHK(rd, 32'h0000000E, "unmapped write leaked")
    `CHK(rd_resp, LCDDC_RESP_OKAY, "read resp")
    axi_rd(16'h0100, rd);
    `CHK(rd_resp, LCDDC_RESP_SLVERR, "unmapped read accepted")
    // Lane 0 masked: the write is answered but changes nothing
    wr_strb = 4'h0;
    axi_wr(BOOST_A, 8'hFF, resp);
    wr_strb = 4'hF;
    `CHK(resp, LCDDC_RESP_OKAY, "masked write resp")
    axi_rd(BOOST_A, rd);
    `CHK(rd, 32'h0000000E, "masked write landed")
    sense <= 1'b1;
    @(posedge clk_i);
    wait_wdog(1'b0);
    `CHK(wdog, 1'b0, "watchdog on with strap")
    axi_rd(STAT_A, rd);
    `CHK(rd, 32'h00000002, "status with strap")
    sense <= 1'b0;
    @(posedge clk_i);
    wait_wdog(1'b1);
    `CHK(wdog, 1'b1, "watchdog off without strap")
    axi_wr(DISP_A, 8'h25, resp);
    axi_rd(DISP_A, rd);
    `CHK(rd, 32'h00000025, "recommended setting readback")
    // Counter restarts at enable, so the first step lands 2^15 cycles after the write
    wait_com(cyc);
    `CHK(cyc > 32700 && cyc <= 32768, 1'b1, "rate 01 period")
    `CHK(unb, 1'b0, "glass driven on grounded rails")
    end_sim();
  end
endmodule : lcd_drive_control_tb
`default_nettype wire
